// ===== core/smla_pkg.sv
// Shared constants and state type for the synchronous modem line adapter
package smla_pkg;
   // ----------------------------------------
   // Sizes and timing
   // ----------------------------------------
   localparam int LINES = 4;
   localparam int CLK_HZ = 10_000_000;
   localparam int MAX_BIT_RATE = 20_000;
   localparam int BIT_CYC_MIN = CLK_HZ / MAX_BIT_RATE;
   localparam int TEST_RATE_MIN = 4800;
   // ----------------------------------------
   // Register map (line n at n*8 + offset)
   // ----------------------------------------
   localparam logic [2:0] OFS_CTRL = 3'h0;
   localparam logic [2:0] OFS_RX_SYNC = 3'h1;
   localparam logic [2:0] OFS_TX_SYNC = 3'h2;
   localparam logic [2:0] OFS_DATA = 3'h3;
   localparam logic [2:0] OFS_STATUS = 3'h4;
   localparam logic [5:0] ADR_IRQ_STATUS = 6'h20;
   localparam logic [5:0] ADR_IRQ_CLEAR = 6'h21;
   localparam logic [5:0] ADR_IRQ_ENABLE = 6'h22;
   localparam logic [5:0] ADR_SVC = 6'h23;
   // ----------------------------------------
   // Control and status bits
   // ----------------------------------------
   localparam int CB_TRANSMIT = 0;
   localparam int CB_RECEIVE = 1;
   localparam int CB_DEL_SYNC = 2;
   localparam int CB_IRQ_UF = 3;
   localparam int CB_STOP_OUT = 4;
   localparam int SB_RX_FULL = 0;
   localparam int SB_TX_EMPTY = 1;
   localparam int SB_PAR_ERR = 2;
   localparam int SB_OVERRUN = 3;
   localparam int SB_OVERFLOW = 4;
   localparam int SB_UNDERFLOW = 5;
   localparam int SB_SYNCED = 6;
   localparam int EV_PER_LINE = 3;
   localparam int EV_RX = 0;
   localparam int EV_UF = 1;
   localparam int EV_ERR = 2;
   localparam int IRQ_W = LINES * EV_PER_LINE;
   // ----------------------------------------
   // Service kinds, character format
   // ----------------------------------------
   localparam logic [1:0] SVC_NONE = 2'h0;
   localparam logic [1:0] SVC_IN_DATA = 2'h1;
   localparam logic [1:0] SVC_OUT_DATA = 2'h2;
   localparam logic [1:0] SVC_IN_STATUS = 2'h3;
   localparam logic [3:0] LEN_BASE = 4'h5;
   localparam logic [3:0] SH_W = 4'h9;
   localparam logic [3:0] BYTE_W = 4'h8;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [1:0] CFG_LEN_RST = 2'h3;
   localparam logic CFG_PAR_RST = 1'b0;
   localparam logic CFG_ODD_RST = 1'b1;

   typedef enum logic [0:0] {RXM_SEARCH = 1'b0, RXM_CHAR = 1'b1} smla_rxm_e;

   typedef struct packed {
      logic [LINES-1:0] tmode, rmode, del_sync, irq_uf, stop_out;
      logic [LINES-1:0][7:0] rx_sync, tx_sync, tx_buf, rx_buf;
      logic [LINES-1:0] tx_full, rx_full;
      logic [LINES-1:0][8:0] rx_sh, tx_sh;
      logic [LINES-1:0][3:0] rx_cnt, tx_cnt;
      smla_rxm_e [LINES-1:0] rx_mode;
      logic [LINES-1:0] txd, rts;
      logic [LINES-1:0] err_par, err_ovr, err_ovf, uf_pend;
      logic [LINES-1:0] rxc_prev, txc_prev;
      logic [LINES-1:0][1:0] cfg_len;
      logic [LINES-1:0] cfg_par_en, cfg_odd;
      logic cfg_done;
      logic [LINES-1:0] idr_l, odr_l, sir_l;
      logic svc_valid;
      logic [1:0] svc_line, svc_kind;
      logic [IRQ_W-1:0] irq_st, irq_en;
      logic irq;
      logic [7:0] rdata;
   } smla_state_s;
endpackage

// ===== core/smla_top.sv
// Four-line synchronous modem line adapter core
//
// How it works
// - Four independent full-duplex lines up to 20 kbit/s
// - One held character each way per line
// - Optionally drop received receive-sync characters
// - Send transmit-sync character when output runs dry
// - Generate and check odd, even or no parity
// - Character length 5 to 8 by straps
// - Separate receive and transmit sync stores
// - Report parity, overflow and overrun errors
// - Test clock used directly, no divide-by-16
// - Per-line format, default 8 bits, no parity, odd
// - Input data beats output data beats status
// - Output request gated by buffer, mode, stop, underflow
`timescale 1ns/10ps
`default_nettype none
module smla_top
   import smla_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Modem side
   input wire logic [LINES-1:0] rx_clk,
   input wire logic [LINES-1:0] tx_clk,
   input wire logic [LINES-1:0] rx_data,
   output logic [LINES-1:0] tx_data,
   output logic [LINES-1:0] rts,
   // Backplane test clock
   input wire logic test_clk,
   input wire logic test_sel,
   // Per-line format straps
   input wire logic [LINES-1:0][1:0] strap_len,
   input wire logic [LINES-1:0] strap_par_en,
   input wire logic [LINES-1:0] strap_par_odd,
   // Service request and interrupt
   output logic svc_valid,
   output logic [1:0] svc_line,
   output logic [1:0] svc_kind,
   output logic irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   smla_state_s q, n;
   logic [LINES-1:0] drop_ev, dlvr_ev, sync_ld_ev, data_ld_ev;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic sel, rxb, txb, exp_par, found;
      logic [3:0] dlen, fw;
      logic [7:0] mask, data, rdv;
      logic [8:0] sh, frame;
      logic [IRQ_W-1:0] ev;
      sel = 1'b0;
      rxb = 1'b0;
      txb = 1'b0;
      exp_par = 1'b0;
      found = 1'b0;
      dlen = '0;
      fw = '0;
      mask = '0;
      data = '0;
      rdv = '0;
      sh = '0;
      frame = '0;
      ev = '0;
      n = q;
      drop_ev = '0;
      dlvr_ev = '0;
      sync_ld_ev = '0;
      data_ld_ev = '0;
      // Straps are caught once, just after reset is released
      if (!q.cfg_done) begin
         n.cfg_len = strap_len;
         n.cfg_par_en = strap_par_en;
         n.cfg_odd = strap_par_odd;
         n.cfg_done = 1'b1;
      end
      for (int i = 0; i < LINES; i++) begin
         sel = !addr[5] && (addr[4:3] == i[1:0]);
         dlen = LEN_BASE + {2'b00, q.cfg_len[i]};
         fw = dlen + {3'b000, q.cfg_par_en[i]};
         mask = ALL_ONES >> (BYTE_W - dlen);
         // Bus side first, so that hardware events below win over clears
         if (wr && sel) begin
            unique case (addr[2:0])
               OFS_CTRL: begin
                  n.tmode[i] = wdata[CB_TRANSMIT];
                  n.rmode[i] = wdata[CB_RECEIVE];
                  n.del_sync[i] = wdata[CB_DEL_SYNC];
                  n.irq_uf[i] = wdata[CB_IRQ_UF];
                  n.stop_out[i] = wdata[CB_STOP_OUT];
               end
               OFS_RX_SYNC: n.rx_sync[i] = wdata;
               OFS_TX_SYNC: n.tx_sync[i] = wdata;
               OFS_DATA: begin
                  n.tx_buf[i] = wdata;
                  n.tx_full[i] = 1'b1;
               end
               default: ;
            endcase
         end
         if (rd && sel && addr[2:0] == OFS_DATA) begin
            n.rx_full[i] = 1'b0;
         end
         if (rd && sel && addr[2:0] == OFS_STATUS) begin
            n.err_par[i] = 1'b0;
            n.err_ovr[i] = 1'b0;
            n.err_ovf[i] = 1'b0;
            n.uf_pend[i] = 1'b0;
         end
         // Bit clocks: modem clocks, or the raw test clock with no prescale
         rxb = test_sel ? test_clk : rx_clk[i];
         txb = test_sel ? test_clk : tx_clk[i];
         n.rxc_prev[i] = rxb;
         n.txc_prev[i] = txb;
         // Receiver
         if (!q.rmode[i]) begin
            n.rx_mode[i] = RXM_SEARCH;
            n.rx_cnt[i] = '0;
         end else if (rxb && !q.rxc_prev[i]) begin
            sh = {rx_data[i], q.rx_sh[i][8:1]};
            n.rx_sh[i] = sh;
            if (q.rx_mode[i] == RXM_SEARCH) begin
               // Bit-by-bit hunt; the window spans the parity bit too, so
               // the next character starts on its first data bit
               frame = sh >> (SH_W - fw);
               if ((frame[7:0] & mask) == (q.rx_sync[i] & mask)) begin
                  n.rx_mode[i] = RXM_CHAR;
                  n.rx_cnt[i] = '0;
               end
            end else if (q.rx_cnt[i] + 4'h1 == fw) begin
               n.rx_cnt[i] = '0;
               frame = sh >> (SH_W - fw);
               data = frame[7:0] & mask;
               exp_par = q.cfg_odd[i] ? ~^data : ^data;
               found = q.cfg_par_en[i] && (frame[dlen] != exp_par);
               if (q.del_sync[i] && data == (q.rx_sync[i] & mask)) begin
                  drop_ev[i] = 1'b1;
               end else begin
                  dlvr_ev[i] = 1'b1;
                  n.rx_buf[i] = data;
                  n.rx_full[i] = 1'b1;
                  ev[i*EV_PER_LINE+EV_RX] = 1'b1;
                  // Second loss before status is read counts as overflow
                  if (q.rx_full[i] && q.err_ovr[i]) begin
                     n.err_ovf[i] = 1'b1;
                     ev[i*EV_PER_LINE+EV_ERR] = 1'b1;
                  end else if (q.rx_full[i]) begin
                     n.err_ovr[i] = 1'b1;
                     ev[i*EV_PER_LINE+EV_ERR] = 1'b1;
                  end
                  if (found) begin
                     n.err_par[i] = 1'b1;
                     ev[i*EV_PER_LINE+EV_ERR] = 1'b1;
                  end
               end
            end else begin
               n.rx_cnt[i] = q.rx_cnt[i] + 4'h1;
            end
         end
         // Transmitter: line idles marking outside transmission mode
         n.rts[i] = q.tmode[i];
         if (!q.tmode[i]) begin
            n.txd[i] = 1'b1;
            n.tx_cnt[i] = '0;
         end else if (txb && !q.txc_prev[i]) begin
            if (q.tx_cnt[i] == '0) begin
               if (q.tx_full[i]) begin
                  data = q.tx_buf[i] & mask;
                  data_ld_ev[i] = 1'b1;
                  n.tx_full[i] = wr && sel && addr[2:0] == OFS_DATA;
               end else begin
                  // Nothing ready in time: keep sync with the idle pattern
                  data = q.tx_sync[i] & mask;
                  sync_ld_ev[i] = 1'b1;
                  ev[i*EV_PER_LINE+EV_UF] = 1'b1;
                  if (q.irq_uf[i]) begin
                     n.uf_pend[i] = 1'b1;
                  end
               end
               frame = {1'b0, data};
               if (q.cfg_par_en[i]) begin
                  frame[dlen] = q.cfg_odd[i] ? ~^data : ^data;
               end
               n.txd[i] = frame[0];
               n.tx_sh[i] = frame >> 1;
               n.tx_cnt[i] = fw - 4'h1;
            end else begin
               n.txd[i] = q.tx_sh[i][0];
               n.tx_sh[i] = q.tx_sh[i] >> 1;
               n.tx_cnt[i] = q.tx_cnt[i] - 4'h1;
            end
         end
         // Service request terms, latched one cycle
         n.idr_l[i] = q.rx_full[i];
         n.odr_l[i] = !q.tx_full[i] && q.tmode[i] && !q.stop_out[i] && !q.uf_pend[i];
         n.sir_l[i] = q.uf_pend[i];
         // Read mux for line registers
         if (sel) begin
            unique case (addr[2:0])
               OFS_CTRL: rdv = {3'h0, q.stop_out[i], q.irq_uf[i], q.del_sync[i],
                                q.rmode[i], q.tmode[i]};
               OFS_RX_SYNC: rdv = q.rx_sync[i];
               OFS_TX_SYNC: rdv = q.tx_sync[i];
               OFS_DATA: rdv = q.rx_buf[i];
               OFS_STATUS: begin
                  rdv = '0;
                  rdv[SB_RX_FULL] = q.rx_full[i];
                  rdv[SB_TX_EMPTY] = !q.tx_full[i];
                  rdv[SB_PAR_ERR] = q.err_par[i];
                  rdv[SB_OVERRUN] = q.err_ovr[i];
                  rdv[SB_OVERFLOW] = q.err_ovf[i];
                  rdv[SB_UNDERFLOW] = q.uf_pend[i];
                  rdv[SB_SYNCED] = (q.rx_mode[i] == RXM_CHAR);
               end
               default: ;
            endcase
         end
      end
      // Priority: any input data, then output data, then status
      n.svc_valid = 1'b0;
      n.svc_kind = SVC_NONE;
      n.svc_line = '0;
      for (int i = LINES - 1; i >= 0; i--) begin
         if (q.sir_l[i]) begin
            n.svc_valid = 1'b1;
            n.svc_kind = SVC_IN_STATUS;
            n.svc_line = i[1:0];
         end
      end
      for (int i = LINES - 1; i >= 0; i--) begin
         if (q.odr_l[i] && q.idr_l == '0) begin
            n.svc_valid = 1'b1;
            n.svc_kind = SVC_OUT_DATA;
            n.svc_line = i[1:0];
         end
      end
      for (int i = LINES - 1; i >= 0; i--) begin
         if (q.idr_l[i]) begin
            n.svc_valid = 1'b1;
            n.svc_kind = SVC_IN_DATA;
            n.svc_line = i[1:0];
         end
      end
      // Interrupt: write-one clear, a new event in the same cycle wins
      if (addr[5]) begin
         unique case (addr)
            ADR_IRQ_STATUS: rdv = q.irq_st[7:0];
            ADR_IRQ_ENABLE: rdv = q.irq_en[7:0];
            ADR_SVC: rdv = {q.svc_valid, 3'h0, q.svc_kind, q.svc_line};
            default: rdv = '0;
         endcase
      end
      if (rd && addr == ADR_IRQ_STATUS + 6'h4) begin
         rdv = {4'h0, q.irq_st[IRQ_W-1:8]};
      end
      if (wr && addr == ADR_IRQ_ENABLE) begin
         n.irq_en[7:0] = wdata;
      end
      if (wr && addr == ADR_IRQ_ENABLE + 6'h4) begin
         n.irq_en[IRQ_W-1:8] = wdata[3:0];
      end
      n.irq_st = q.irq_st;
      if (wr && addr == ADR_IRQ_CLEAR) begin
         n.irq_st[7:0] = q.irq_st[7:0] & ~wdata;
      end
      if (wr && addr == ADR_IRQ_CLEAR + 6'h4) begin
         n.irq_st[IRQ_W-1:8] = q.irq_st[IRQ_W-1:8] & ~wdata[3:0];
      end
      n.irq_st = n.irq_st | ev;
      n.irq = |(n.irq_st & n.irq_en);
      n.rdata = rd ? rdv : '0;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
         q.txd <= '1;
         q.rxc_prev <= '1;
         q.txc_prev <= '1;
         q.cfg_len <= {LINES{CFG_LEN_RST}};
         q.cfg_par_en <= {LINES{CFG_PAR_RST}};
         q.cfg_odd <= {LINES{CFG_ODD_RST}};
      end else begin
         q <= n;
      end
   end

   assign rdata = q.rdata;
   assign tx_data = q.txd;
   assign rts = q.rts;
   assign svc_valid = q.svc_valid;
   assign svc_line = q.svc_line;
   assign svc_kind = q.svc_kind;
   assign irq = q.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_out_req_gate: assert property (q.odr_l[0] |->
      $past(!q.tx_full[0] && q.tmode[0] && !q.stop_out[0] && !q.uf_pend[0]))
      else $error("output request raised while gated");
   chk_svc_priority: assert property (q.idr_l != '0 |=> q.svc_kind == SVC_IN_DATA)
      else $error("input data request not served first");
   chk_out_over_stat: assert property ((q.odr_l != '0 && q.idr_l == '0) |=>
      q.svc_kind == SVC_OUT_DATA)
      else $error("output request lost to status");
   chk_sync_drop: assert property (drop_ev[0] |=> $stable(q.rx_buf[0]) &&
      q.rx_full[0] == $past(q.rx_full[0] && !(rd && addr == {3'h0, OFS_DATA})))
      else $error("dropped sync reached receive buffer");
   chk_sync_fill: assert property (sync_ld_ev[1] |=>
      q.txd[1] == $past(q.tx_sync[1][0]) && q.irq_st[EV_PER_LINE + EV_UF])
      else $error("sync fill sent wrong first bit");
   chk_overrun_flag: assert property ((dlvr_ev[0] && q.rx_full[0] && !q.err_ovr[0]) |=>
      q.err_ovr[0] && q.irq_st[EV_ERR])
      else $error("overrun not reported");
   chk_tx_hold: assert property ((wr && addr == {3'h0, OFS_DATA}) |=>
      q.tx_full[0] && q.tx_buf[0] == $past(wdata))
      else $error("transmit character not held");
   chk_sync_stores: assert property ((wr && addr == {3'h0, OFS_RX_SYNC}) |=>
      $stable(q.tx_sync[0]))
      else $error("receive sync write disturbed transmit sync");
   chk_test_clock: assert property (test_sel |=> q.rxc_prev == {LINES{$past(test_clk)}})
      else $error("test clock not used undivided");
   chk_cfg_default: assert property ($fell(reset) |->
      q.cfg_len[0] == CFG_LEN_RST && !q.cfg_par_en[0] && q.cfg_odd[0])
      else $error("format default wrong after reset");
   chk_irq_level: assert property (q.irq == |(q.irq_st & q.irq_en))
      else $error("interrupt level disagrees with status");
endmodule
`default_nettype wire

// ===== tb/smla_modem.sv
// Loopback synchronous modem model for the four lines
`timescale 1ns/10ps
`default_nettype none
module smla_modem
   import smla_pkg::*;
#(
   parameter int HALF = BIT_CYC_MIN / 2
)(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bench control
   input wire logic [LINES-1:0] run,
   // Line side
   input wire logic [LINES-1:0] tx_data,
   output logic [LINES-1:0] tx_clk,
   output logic [LINES-1:0] rx_clk,
   output logic [LINES-1:0] rx_data
);
   // ----------------------------------------
   // Bit clock at the highest rated speed
   // ----------------------------------------
   int cnt_q;
   logic phase_q;
   logic [LINES-1:0] noise_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= 0;
         phase_q <= 1'b0;
         noise_q <= '0;
      end else begin
         noise_q <= ~noise_q;
         if (cnt_q == HALF - 1) begin
            cnt_q <= 0;
            phase_q <= ~phase_q;
         end else begin
            cnt_q <= cnt_q + 1;
         end
      end
   end
   // ----------------------------------------
   // Line outputs
   // ----------------------------------------
   // Clocks stand low on an idle line; receive clock rises mid-bit
   assign tx_clk = run & {LINES{phase_q}};
   assign rx_clk = run & {LINES{~phase_q}};
   // An idle line toggles so no stale level can pass for data
   assign rx_data = (run & tx_data) | (~run & noise_q);
endmodule
`default_nettype wire

// ===== tb/smla_top_test.sv
// Self-checking bench for the modem line adapter
`timescale 1ns/10ps
`default_nettype none
module smla_top_test;
   import smla_pkg::*;
   localparam int HALF = BIT_CYC_MIN / 2;
   localparam int CHAR_CYC = 9 * 2 * HALF;
   localparam logic [7:0] SYNC = 8'h03;
   logic clk, reset, wr, rd, test_sel, svc_valid, irq;
   logic test_clk = 1'b0;
   logic txp;
   logic [5:0] addr;
   logic [7:0] wdata, rdata;
   logic [LINES-1:0] rx_clk, tx_clk, rx_data, tx_data, rts, run, par_en, par_odd;
   logic [LINES-1:0][1:0] strap_len;
   logic [1:0] svc_line, svc_kind, l;
   logic [7:0] exp_q[$];
   logic [7:0] msk_q[$];
   logic [7:0] chr[LINES];
   logic [7:0] msk[LINES];
   logic [31:0] seed;
   logic rd_d = 1'b0;
   int fails, cmp_count, hits;
   smla_top u_smla_top (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .rx_clk(rx_clk), .tx_clk(tx_clk), .rx_data(rx_data),
      .tx_data(tx_data), .rts(rts), .test_clk(test_clk), .test_sel(test_sel),
      .strap_len(strap_len), .strap_par_en(par_en), .strap_par_odd(par_odd),
      .svc_valid(svc_valid), .svc_line(svc_line), .svc_kind(svc_kind), .irq(irq));
   smla_modem #(.HALF(HALF)) u_smla_modem (.clk(clk), .reset(reset), .run(run),
      .tx_data(tx_data), .tx_clk(tx_clk), .rx_clk(rx_clk), .rx_data(rx_data));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   function automatic logic [5:0] adr(input int n, input logic [2:0] o);
      return {n[2:0], o};
   endfunction
   // Strobe lowered then one edge passes, so no double drive per step
   task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic reg_rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   // Request terms lag their cause, so let stale ones drain first
   task automatic wait_svc(input logic [1:0] kind, output logic [1:0] line);
      int i;
      i = 0;
      repeat (3) @(posedge clk);
      while (!(svc_valid === 1'b1 && svc_kind === kind) && i < 2 * CHAR_CYC) begin
         @(posedge clk);
         i++;
      end
      check({svc_valid, 5'h0, svc_kind}, {1'b1, 5'h0, kind});
      line = svc_line;
   endtask
   // ----------------------------------------
   // Read data monitor
   // ----------------------------------------
   always @(posedge clk) begin
      if (rd_d === 1'b1) check(rdata & msk_q.pop_front(), exp_q.pop_front());
      rd_d <= rd;
      // Half the system clock, far above the lowest usable test rate
      test_clk <= ~test_clk;
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      test_done();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset = 1'b1;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      run = '0;
      test_sel = 1'b0;
      strap_len = {2'h1, 2'h0, 2'h2, 2'h3};
      par_en = 4'h6;
      par_odd = 4'h2;
      seed = 32'h0000_42c8;
      fails = 0;
      cmp_count = 0;
      for (int n = 0; n < LINES; n++) msk[n] = 8'hff >> (2'h3 - strap_len[n]);
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check({4'h0, tx_data}, 8'h0f);
      reg_rd(6'h3f, 8'h00, 8'hff);
      reg_rd(adr(0, OFS_CTRL), 8'h00, 8'hff);
      for (int n = 0; n < LINES; n++) begin
         reg_wr(adr(n, OFS_RX_SYNC), SYNC);
         reg_wr(adr(n, OFS_TX_SYNC), SYNC);
         reg_wr(adr(n, OFS_CTRL), (n == 0) ? 8'h17 : 8'h07);
      end
      run <= 4'hf;
      @(posedge clk);
      check({4'h0, rts}, 8'h0f);
      // Stop-output holds off line 0, so line 1 wins the output request
      wait_svc(SVC_OUT_DATA, l);
      check({6'h0, l}, 8'h01);
      reg_wr(adr(0, OFS_CTRL), 8'h07);
      wait_svc(SVC_OUT_DATA, l);
      check({6'h0, l}, 8'h00);
      // Sync fill only: deleted syncs must raise no input request
      hits = 0;
      repeat (4 * CHAR_CYC) begin
         @(posedge clk);
         if (svc_kind === SVC_IN_DATA) hits++;
      end
      check(hits[7:0], 8'h00);
      for (int n = 0; n < LINES; n++) reg_rd(adr(n, OFS_STATUS), 8'h40, 8'h40);
      reg_rd(ADR_IRQ_STATUS, 8'h92, 8'h92);
      reg_rd(ADR_IRQ_STATUS + 6'h04, 8'h04, 8'h04);
      reg_wr(ADR_IRQ_ENABLE, 8'h02);
      repeat (3) @(posedge clk);
      check({7'h0, irq}, 8'h01);
      // Clear just after a bit clock edge, so no new fill lands in the window
      @(posedge tx_clk[0]);
      repeat (2) @(posedge clk);
      reg_wr(ADR_IRQ_CLEAR, 8'h02);
      repeat (3) @(posedge clk);
      check({7'h0, irq}, 8'h00);
      reg_wr(ADR_IRQ_ENABLE, 8'h00);
      // One character per line, all lines at once
      for (int n = 0; n < LINES; n++) begin
         seed = xs(seed);
         chr[n] = seed[7:0] & msk[n];
         if (chr[n] === (SYNC & msk[n])) chr[n] = 8'h10 & msk[n];
         reg_wr(adr(n, OFS_DATA), chr[n]);
      end
      for (int k = 0; k < LINES; k++) begin
         wait_svc(SVC_IN_DATA, l);
         reg_rd(adr(l, OFS_STATUS), 8'h01, 8'h05);
         reg_rd(adr(l, OFS_DATA), chr[l], msk[l]);
      end
      // Second character left unread, third one arrives on a full buffer
      seed = xs(seed);
      reg_wr(adr(0, OFS_DATA), seed[7:0] | 8'h80);
      wait_svc(SVC_IN_DATA, l);
      check({6'h0, l}, 8'h00);
      reg_wr(adr(0, OFS_DATA), seed[15:8] | 8'h40);
      repeat (2 * CHAR_CYC) @(posedge clk);
      reg_rd(adr(0, OFS_STATUS), 8'h08, 8'h08);
      reg_rd(adr(0, OFS_STATUS), 8'h00, 8'h0c);
      // Test clock taken as is: one 8-bit sync fill, one rise, per 16 cycles
      test_sel <= 1'b1;
      repeat (40) @(posedge clk);
      hits = 0;
      txp = tx_data[0];
      repeat (160) begin
         @(posedge clk);
         if (tx_data[0] === 1'b1 && txp === 1'b0) hits++;
         txp = tx_data[0];
      end
      check(hits[7:0], 8'h0a);
      repeat (2) @(posedge clk);
      test_done();
   end
endmodule
`default_nettype wire
